/* File: cbmc_core.sv */
// Cell balance mode control: mode decode, timers, write blocking and switch drive.
//
// Contract
// - Writing a nonzero mode starts balancing until rewrite or exit.
// - Status cleared only by a mode write.
// - Alive counter advances once per second while balancing is active.
// - Health check before start; failure sets flag.
// - Exits keep mode, stop switches, keep status.
// - Blocked writes are dropped and flag rejection.
// - Blocking set depends on automatic, manual, emergency.
// - Refresh strobe acts only in manual mode.
// - Manual mode accepts switch enable writes.
// - Lowest-cell exit write rejected during scan.
// - Any nonzero mode write restarts timer at zero.
// - Manual switch: enable, timer limit, pause gating.
// - Manual timer runs in real time always.
// - All-ones limit disables the manual watchdog.
// - Manual mode ignores undervoltage exit level.
// - After manual expiry refresh does nothing.
// - Pause option stops switches during measurement, manual.
// - Settle delay counts in 96 us steps.
// - Settle register holds cell and wire delays.
// - Alternate mux selects wire delay, only with pause option on.
// - Settle writes rejected during measure or automatic.
// - Timer ignores the pause option.
// - Mode field decodes emergency, manual, automatic variants.
// - Exit state 10 normal, 11 fault.
`timescale 1ns/100ps
`default_nettype none

module cbmc_core #(
  parameter int unsigned CELLS     = cbmc_pkg::CELLS,
  parameter int unsigned SEC_CYC   = cbmc_pkg::SEC_CYCLES,
  parameter int unsigned STEP_CYC  = cbmc_pkg::STEP_CYCLES
) (
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_n_i,
  input  wire cbmc_pkg::cbmc_wr_s          wr_i,
  input  wire logic                        measure_busy_i,
  input  wire logic                        scan_busy_i,
  input  wire logic                        measure_start_i,
  input  wire logic                        pause_switches_in_measure_i,
  input  wire logic                        alternate_mux_select_i,
  input  wire logic                        thermal_fault_i,
  input  wire logic                        cal_fault_i,
  input  wire logic                        uv_reached_i,
  input  wire logic                        health_ok_i,
  input  wire logic [CELLS-1:0]            auto_switch_i,
  output cbmc_pkg::cbmc_stat_s             status_o,
  output logic [cbmc_pkg::MODE_W-1:0]      balance_mode_select_o,
  output logic [CELLS-1:0]                 switch_enable_mask_o,
  output logic [cbmc_pkg::EXP_W-1:0]       first_expiry_limit_o,
  output logic [cbmc_pkg::DELAY_W-1:0]     cell_settle_delay_o,
  output logic [cbmc_pkg::DELAY_W-1:0]     wire_settle_delay_o,
  output logic                             exit_level_from_lowest_o,
  output logic                             notify_wr_o,
  output logic [CELLS-1:0]                 switch_drive_o,
  output logic                             settle_busy_o,
  output logic                             settle_done_o
);

  // Decode the mode field into one of four kinds.
  function automatic cbmc_pkg::cbmc_kind_e kind_of(input logic [2:0] m);
    if (m[cbmc_pkg::MODE_AUTO_BIT])
      return cbmc_pkg::CBMC_AUTO;
    else if (m[cbmc_pkg::MODE_MANUAL_BIT])
      return cbmc_pkg::CBMC_MANUAL;
    else if (m == cbmc_pkg::MODE_EMERGENCY)
      return cbmc_pkg::CBMC_EMERG;
    else
      return cbmc_pkg::CBMC_OFF;
  endfunction

  // Stored configuration and state.
  logic [2:0]                    mode_r;        // Mode field as written.
  logic [CELLS-1:0]              mask_r;        // Per-cell enables.
  logic [9:0]                    exp_r;         // First expiry limit.
  logic [7:0]                    cdly_r;        // Cell settle delay.
  logic [7:0]                    wdly_r;        // Wire settle delay.
  logic                          lowest_r;      // Exit level from lowest cell.
  logic [1:0]                    state_r;       // Balancing state.
  logic [9:0]                    timer_r;       // Balancing timer.
  logic [1:0]                    alive_r;       // Alive counter.
  logic [1:0]                    unit_r;        // Timer units.
  logic                          hfail_r;       // Health check failure.
  logic                          reject_r;      // Write rejected flag.
  logic                          expired_r;     // Timer passed its limit.
  logic [31:0]                   sec_r;         // One-second prescaler.
  logic [11:0]                   unit_cnt_r;    // Seconds within a timer unit.
  logic                          notify_r;      // Accepted notify write pulse.
  logic                          sec_tick;
  logic                          unit_tick;
  logic                          start;
  logic                          running;
  cbmc_pkg::cbmc_kind_e          kind;
  logic [11:0]                   unit_len;
  logic                          rej_uv;
  logic                          rej_exp;
  logic                          rej_sw;
  logic                          rej_dly;
  logic                          rej_notify;
  logic                          reject_evt;
  logic                          within_limit;

  assign kind    = kind_of(mode_r);
  assign start   = wr_i.ctrl_we && (wr_i.mode != cbmc_pkg::MODE_DISABLE);
  assign running = (state_r == cbmc_pkg::STATE_ACTIVE);

  // Seconds per timer tick follow the unit of the running mode.
  always_comb begin
    case (unit_r)
      cbmc_pkg::UNIT_MINUTE: unit_len = 12'(cbmc_pkg::SEC_PER_MIN);
      cbmc_pkg::UNIT_HOUR:   unit_len = 12'(cbmc_pkg::SEC_PER_HOUR);
      default:               unit_len = 12'h001;
    endcase
  end

  // Blocking: after start, any non-disabled mode blocks per its kind.
  always_comb begin
    rej_sw     = (kind == cbmc_pkg::CBMC_AUTO) && wr_i.sw_we;
    rej_exp    = (kind != cbmc_pkg::CBMC_OFF) && wr_i.exp_we;
    rej_notify = ((kind == cbmc_pkg::CBMC_AUTO) || (kind == cbmc_pkg::CBMC_EMERG)) && wr_i.notify_we;
    rej_uv     = wr_i.uv_we && ((kind == cbmc_pkg::CBMC_AUTO) || (wr_i.uv_lowest && scan_busy_i));
    rej_dly    = wr_i.dly_we && ((kind == cbmc_pkg::CBMC_AUTO)
                                 || measure_busy_i || settle_busy_o);
    reject_evt = rej_sw || rej_exp || rej_notify || rej_uv || rej_dly;
  end

  // One-second prescaler restarts with each launch so ticks align to the start.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || start) begin
      sec_r <= 32'h0000_0000;
    end else if (sec_r == 32'(SEC_CYC - 1)) begin
      sec_r <= 32'h0000_0000;
    end else begin
      sec_r <= sec_r + 32'h0000_0001;
    end
  end
  assign sec_tick = (sec_r == 32'(SEC_CYC - 1));

  // Seconds are gathered into the mode's timer unit.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || start) begin
      unit_cnt_r <= 12'h000;
    end else if (sec_tick) begin
      unit_cnt_r <= (unit_cnt_r == unit_len - 12'h001) ? 12'h000 : unit_cnt_r + 12'h001;
    end
  end
  assign unit_tick = sec_tick && (unit_cnt_r == unit_len - 12'h001);

  // Configuration writes land unless blocked by the mode or a busy scan, measurement or settle; mode writes always land.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      mode_r   <= cbmc_pkg::MODE_DISABLE;
      mask_r   <= '0;
      exp_r    <= cbmc_pkg::EXP_RESET;
      cdly_r   <= cbmc_pkg::DELAY_RESET;
      wdly_r   <= cbmc_pkg::DELAY_RESET;
      lowest_r <= 1'b0;
      notify_r <= 1'b0;
    end else begin
      notify_r <= wr_i.notify_we && !rej_notify;
      if (wr_i.ctrl_we) begin
        mode_r <= wr_i.mode;
      end
      if (wr_i.sw_we && !rej_sw) begin
        mask_r <= wr_i.sw_mask;
      end
      if (wr_i.exp_we && !rej_exp) begin
        exp_r <= wr_i.exp_val;
      end
      if (wr_i.uv_we && !rej_uv) begin
        lowest_r <= wr_i.uv_lowest;
      end
      if (wr_i.dly_we && !rej_dly) begin
        cdly_r <= wr_i.cell_dly;
        wdly_r <= wr_i.wire_dly;
      end
    end
  end

  // Rejected writes set a sticky flag; a mode write clears it, but a reject wins.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      reject_r <= 1'b0;
    end else if (reject_evt) begin
      reject_r <= 1'b1;
    end else if (wr_i.ctrl_we) begin
      reject_r <= 1'b0;
    end
  end

  // Balancing state: launch, then exit by timer, faults or undervoltage.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_r <= cbmc_pkg::STATE_IDLE;
      hfail_r <= 1'b0;
      unit_r  <= cbmc_pkg::UNIT_SECOND;
    end else if (wr_i.ctrl_we) begin
      // Only a mode write clears the status fields.
      hfail_r <= 1'b0;
      unit_r  <= cbmc_pkg::UNIT_SECOND;
      state_r <= cbmc_pkg::STATE_IDLE;
      if (start) begin
        // The health check is sampled before the switches may turn on.
        if (!health_ok_i) begin
          hfail_r <= 1'b1;
          state_r <= cbmc_pkg::STATE_FAULT;
        end else begin
          state_r <= cbmc_pkg::STATE_ACTIVE;
        end
        if (wr_i.mode == cbmc_pkg::MODE_EMERGENCY) begin
          unit_r <= cbmc_pkg::UNIT_HOUR;
        end else if (wr_i.mode[cbmc_pkg::MODE_AUTO_BIT] && wr_i.mode[cbmc_pkg::MODE_UNIT_BIT]) begin
          unit_r <= cbmc_pkg::UNIT_MINUTE;
        end
      end
    end else if (running) begin
      // Exits keep the mode field; only switches stop and state reports.
      if ((thermal_fault_i || cal_fault_i) && kind != cbmc_pkg::CBMC_MANUAL) begin
        state_r <= cbmc_pkg::STATE_FAULT;
      end else if (expired_r) begin
        state_r <= cbmc_pkg::STATE_NORMAL;
      end else if (uv_reached_i && kind == cbmc_pkg::CBMC_AUTO) begin
        state_r <= cbmc_pkg::STATE_NORMAL;
      end
    end
  end

  // Limit check; manual all-ones limit means no watchdog.
  assign within_limit = (timer_r <= exp_r) ||
                        (kind == cbmc_pkg::CBMC_MANUAL && exp_r == cbmc_pkg::EXP_DISABLE);

  // Timer counts real time units, independent of switches and of pausing.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || wr_i.ctrl_we) begin
      timer_r   <= '0;
      expired_r <= 1'b0;
    end else if (kind == cbmc_pkg::CBMC_MANUAL && wr_i.refresh && running && !expired_r) begin
      timer_r <= '0;
    end else if (unit_tick && kind != cbmc_pkg::CBMC_OFF && !expired_r) begin
      // Saturate so a long run never wraps below the limit.
      if (timer_r != '1) begin
        timer_r <= timer_r + 10'h001;
      end
      if (!within_limit || (timer_r + 10'h001 > exp_r && !(kind == cbmc_pkg::CBMC_MANUAL
          && exp_r == cbmc_pkg::EXP_DISABLE))) begin
        expired_r <= 1'b1;
      end
    end
  end

  // Refresh after expiry is ignored because expired_r blocks it above.

  // Alive counter ticks each second while balancing is active.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || wr_i.ctrl_we) begin
      alive_r <= '0;
    end else if (sec_tick && running) begin
      alive_r <= alive_r + 2'h1;
    end
  end

  // Switch drive per mode, registered so outputs come from flip-flops.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      switch_drive_o <= '0;
    end else if (!running || wr_i.ctrl_we) begin
      switch_drive_o <= '0;
    end else begin
      case (kind)
        cbmc_pkg::CBMC_MANUAL:
          switch_drive_o <= mask_r & {CELLS{within_limit && !expired_r}}
                            & {CELLS{!(pause_switches_in_measure_i && measure_busy_i)}};
        cbmc_pkg::CBMC_AUTO,
        cbmc_pkg::CBMC_EMERG:
          switch_drive_o <= auto_switch_i & {CELLS{!expired_r}};
        default:
          switch_drive_o <= '0;
      endcase
    end
  end

  // Settling delay between acquisition enable and measurement.
  cbmc_settle #(
    .STEP_CYC (STEP_CYC)
  ) u_settle (
    .ref_clk_i  (ref_clk_i),
    .rst_n_i    (rst_n_i),
    .start_i    (measure_start_i),
    .pause_en_i (pause_switches_in_measure_i),
    .alt_mux_i  (alternate_mux_select_i),
    .cell_dly_i (cdly_r),
    .wire_dly_i (wdly_r),
    .busy_o     (settle_busy_o),
    .done_o     (settle_done_o)
  );

  // Status and configuration outputs come straight from flip-flops.
  assign status_o.state       = state_r;
  assign status_o.timer       = timer_r;
  assign status_o.alive       = alive_r;
  assign status_o.unit        = unit_r;
  assign status_o.health_fail = hfail_r;
  assign status_o.reject      = reject_r;
  assign balance_mode_select_o    = mode_r;
  assign switch_enable_mask_o     = mask_r;
  assign first_expiry_limit_o     = exp_r;
  assign cell_settle_delay_o      = cdly_r;
  assign wire_settle_delay_o      = wdly_r;
  assign exit_level_from_lowest_o = lowest_r;
  assign notify_wr_o              = notify_r;

endmodule

`default_nettype wire

/* File: cbmc_pkg.sv */
// Package of constants, types and layouts for the cell balance mode control block.
package cbmc_pkg;

  // Number of balancing switches and field widths.
  localparam int unsigned CELLS       = 14;
  localparam int unsigned MODE_W      = 3;
  localparam int unsigned EXP_W       = 10;
  localparam int unsigned TIMER_W     = 10;
  localparam int unsigned DELAY_W     = 8;
  localparam int unsigned ALIVE_W     = 2;

  // Mode field encodings.
  localparam logic [2:0] MODE_DISABLE   = 3'h0;
  localparam logic [2:0] MODE_EMERGENCY = 3'h1;

  // Mode field bit positions used by the decoder.
  localparam int unsigned MODE_AUTO_BIT   = 2;
  localparam int unsigned MODE_MANUAL_BIT = 1;
  localparam int unsigned MODE_UNIT_BIT   = 0;

  // An all-ones first expiry limit turns the manual watchdog off.
  localparam logic [9:0] EXP_DISABLE = 10'h3FF;

  // Balancing state codes.
  localparam logic [1:0] STATE_IDLE   = 2'h0;
  localparam logic [1:0] STATE_ACTIVE = 2'h1;
  localparam logic [1:0] STATE_NORMAL = 2'h2;
  localparam logic [1:0] STATE_FAULT  = 2'h3;

  // Timer unit codes shown to software.
  localparam logic [1:0] UNIT_SECOND = 2'h0;
  localparam logic [1:0] UNIT_MINUTE = 2'h1;
  localparam logic [1:0] UNIT_HOUR   = 2'h2;

  // Seconds in a minute and in an hour for the unit prescaler.
  localparam int unsigned SEC_PER_MIN  = 60;
  localparam int unsigned SEC_PER_HOUR = 3600;

  // Reset values.
  localparam logic [9:0] EXP_RESET   = 10'h3FF;
  localparam logic [7:0] DELAY_RESET = 8'h00;

  // Clock rate and settle step timing.
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned STEP_NS       = 96_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned STEP_CYCLES   = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SEC_CYCLES    = CLK_HZ;

  // Decoded balancing mode.
  typedef enum logic [1:0] {
    CBMC_OFF,
    CBMC_EMERG,
    CBMC_MANUAL,
    CBMC_AUTO
  } cbmc_kind_e;

  // One host write: strobes with their data.
  typedef struct packed {
    logic                 ctrl_we;
    logic [MODE_W-1:0]    mode;
    logic                 sw_we;
    logic [CELLS-1:0]     sw_mask;
    logic                 refresh;
    logic                 exp_we;
    logic [EXP_W-1:0]     exp_val;
    logic                 uv_we;
    logic                 uv_lowest;
    logic                 dly_we;
    logic [DELAY_W-1:0]   cell_dly;
    logic [DELAY_W-1:0]   wire_dly;
    logic                 notify_we;
  } cbmc_wr_s;

  // Status seen by the host.
  typedef struct packed {
    logic [1:0]           state;
    logic [TIMER_W-1:0]   timer;
    logic [ALIVE_W-1:0]   alive;
    logic [1:0]           unit;
    logic                 health_fail;
    logic                 reject;
  } cbmc_stat_s;

endpackage

/* File: cbmc_settle.sv */
// Settling delay counter that picks the cell or wire delay and counts 96 us steps.
`timescale 1ns/100ps
`default_nettype none

module cbmc_settle #(
  parameter int unsigned STEP_CYC = cbmc_pkg::STEP_CYCLES
) (
  input  wire logic                         ref_clk_i,
  input  wire logic                         rst_n_i,
  input  wire logic                         start_i,
  input  wire logic                         pause_en_i,
  input  wire logic                         alt_mux_i,
  input  wire logic [cbmc_pkg::DELAY_W-1:0] cell_dly_i,
  input  wire logic [cbmc_pkg::DELAY_W-1:0] wire_dly_i,
  output logic                              busy_o,
  output logic                              done_o
);

  // Step prescaler and remaining step count.
  logic [15:0]                   pre_r;
  logic [cbmc_pkg::DELAY_W-1:0]  left_r;
  logic [cbmc_pkg::DELAY_W-1:0]  sel_dly;

  // The selected delay only differs when pausing is on; otherwise cell delay.
  always_comb begin
    sel_dly = (pause_en_i && alt_mux_i) ? wire_dly_i : cell_dly_i;
  end

  // Count whole 96 us steps; a zero delay finishes on the next edge.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      pre_r  <= 16'h0000;
      left_r <= 8'h00;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        busy_o <= 1'b1;
        pre_r  <= 16'h0000;
        left_r <= sel_dly;
      end else if (busy_o) begin
        if (left_r == 8'h00) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else if (pre_r == 16'(STEP_CYC - 1)) begin
          pre_r  <= 16'h0000;
          left_r <= left_r - 8'h01;
        end else begin
          pre_r <= pre_r + 16'h0001;
        end
      end
    end
  end

endmodule

`default_nettype wire

/* File: cbmc_core_monitor.sv */
// Checker of the cell balance mode control ports, bound to the core.
`timescale 1ns/100ps
`default_nettype none
module cbmc_core_monitor #(
  parameter int unsigned CELLS    = cbmc_pkg::CELLS,
  parameter int unsigned STEP_CYC = cbmc_pkg::STEP_CYCLES
) (
  input wire logic                         ref_clk_i,
  input wire logic                         rst_n_i,
  input wire cbmc_pkg::cbmc_wr_s           wr_i,
  input wire logic                         measure_busy_i,
  input wire logic                         scan_busy_i,
  input wire logic                         measure_start_i,
  input wire logic                         pause_switches_in_measure_i,
  input wire logic                         health_ok_i,
  input wire cbmc_pkg::cbmc_stat_s         status_o,
  input wire logic [2:0]                   balance_mode_select_o,
  input wire logic [CELLS-1:0]             switch_enable_mask_o,
  input wire logic [9:0]                   first_expiry_limit_o,
  input wire logic [7:0]                   cell_settle_delay_o,
  input wire logic                         exit_level_from_lowest_o,
  input wire logic                         notify_wr_o,
  input wire logic [CELLS-1:0]             switch_drive_o,
  input wire logic                         settle_busy_o,
  input wire logic                         settle_done_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Decoded views kept as wires so that each property stays short.
  wire logic man = balance_mode_select_o[2:1] == 2'h1;
  wire logic act = status_o.state == cbmc_pkg::STATE_ACTIVE;
  wire logic nz  = wr_i.ctrl_we && wr_i.mode != 3'h0;
  // Longest legal settle run; counted here because it is far too long for a delay range.
  localparam int unsigned SETTLE_MAX = 255 * STEP_CYC + 2;
  logic [31:0] settle_cnt_r;  // Cycles spent busy since the last start.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || measure_start_i) begin
      settle_cnt_r <= 32'h0000_0000;
    end else if (settle_busy_o) begin
      settle_cnt_r <= settle_cnt_r + 32'h0000_0001;
    end
  end
  a_launch_state: assert property (nz && health_ok_i |=> act && status_o.timer == 10'h000) else $error("launch");
  a_mode_kept: assert property (wr_i.ctrl_we |=> balance_mode_select_o == $past(wr_i.mode)) else $error("mode");
  a_health_fail: assert property (nz && !health_ok_i |=> status_o.health_fail && status_o.state == 2'h3)
    else $error("health");
  a_disable_clears: assert property (wr_i.ctrl_we && wr_i.mode == 3'h0 |=> status_o.state == 2'h0
    && status_o.timer == 10'h000 && status_o.alive == 2'h0) else $error("clear");
  a_expiry_blocked: assert property (wr_i.exp_we && act && !wr_i.ctrl_we |=> status_o.reject
    && $stable(first_expiry_limit_o)) else $error("expiry write");
  a_notify_blocked: assert property (wr_i.notify_we && act && balance_mode_select_o == 3'h1 && !wr_i.ctrl_we
    |=> !notify_wr_o && status_o.reject) else $error("notify");
  a_pause_off: assert property (man && act && pause_switches_in_measure_i && measure_busy_i && !wr_i.ctrl_we
    |=> switch_drive_o == '0) else $error("pause");
  a_manual_follow: assert property (man && act && !wr_i.ctrl_we && !wr_i.sw_we && $stable(switch_enable_mask_o)
    && first_expiry_limit_o == 10'h3FF && !(pause_switches_in_measure_i && measure_busy_i)
    |=> switch_drive_o == $past(switch_enable_mask_o)) else $error("manual drive");
  a_off_quiet: assert property (balance_mode_select_o == 3'h0 && !wr_i.ctrl_we |=> switch_drive_o == '0)
    else $error("off drive");
  a_uv_scan: assert property (wr_i.uv_we && wr_i.uv_lowest && scan_busy_i |=> status_o.reject
    && $stable(exit_level_from_lowest_o)) else $error("uv write");
  a_settle_busy: assert property (wr_i.dly_we && measure_busy_i |=> status_o.reject
    && $stable(cell_settle_delay_o)) else $error("settle write");
  a_settle_start: assert property (measure_start_i && !settle_busy_o |=> settle_busy_o)
    else $error("settle start");
  a_settle_bound: assert property (settle_busy_o |-> settle_cnt_r < 32'(SETTLE_MAX))
    else $error("settle long");
  a_settle_end: assert property ($fell(settle_busy_o) |-> settle_done_o)
    else $error("settle end");
  // Main scenarios reached.
  c_manual: cover property (man && act && switch_drive_o != '0);
  c_expired: cover property (status_o.state == 2'h2);
  c_settled: cover property (settle_done_o);
endmodule
bind cbmc_core cbmc_core_monitor #(.CELLS(CELLS), .STEP_CYC(STEP_CYC)) u_mon (.ref_clk_i, .rst_n_i, .wr_i,
  .measure_busy_i,
  .scan_busy_i, .measure_start_i, .pause_switches_in_measure_i, .health_ok_i, .status_o,
  .balance_mode_select_o, .switch_enable_mask_o, .first_expiry_limit_o, .cell_settle_delay_o,
  .exit_level_from_lowest_o, .notify_wr_o, .switch_drive_o, .settle_busy_o, .settle_done_o);
`default_nettype wire

/* File: cbmc_meas_model.sv */
// Behavioural measurement engine beside the balancing block.
`timescale 1ns/100ps
`default_nettype none
module cbmc_meas_model #(
  parameter int unsigned LEN = 6
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic go_i,
  output logic      start_o,
  output logic      busy_o
);
  logic [7:0] cnt_r;  // Cycles of acquisition left.
  // Each request starts one acquisition, free to overlap balancing.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cnt_r <= 8'h00;
      start_o <= 1'b0;
    end else begin
      start_o <= go_i;
      if (go_i) cnt_r <= LEN[7:0];
      else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
    end
  end
  assign busy_o = cnt_r != 8'h00;
endmodule
`default_nettype wire

/* File: test_cbmc_core.sv */
// Self-checking bench of the cell balance mode control core.
`timescale 1ns/100ps
`default_nettype none
module test_cbmc_core;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  cbmc_pkg::cbmc_wr_s w = '0;  // Host write bundle.
  cbmc_pkg::cbmc_stat_s st;
  logic go = 1'b0, mstart, mbusy, pause = 1'b0, alt = 1'b0, hok = 1'b1, therm = 1'b0;
  logic [2:0] mode;
  logic [13:0] mask, drv, asw = 14'h0000;
  logic [9:0] lim;
  logic [7:0] cdl, wdl;
  logic low, ntf, sbusy, sdone;
  int fail_count = 0, check_count = 0, n;
  logic [1:0] a;
  always #25 ref_clk_i = ~ref_clk_i;
  cbmc_core #(.SEC_CYC(20), .STEP_CYC(4)) DUT (.ref_clk_i, .rst_n_i, .wr_i(w), .measure_busy_i(mbusy),
    .scan_busy_i(mbusy), .measure_start_i(mstart), .pause_switches_in_measure_i(pause),
    .alternate_mux_select_i(alt), .thermal_fault_i(therm), .cal_fault_i(1'b0), .uv_reached_i(1'b0),
    .health_ok_i(hok), .auto_switch_i(asw), .status_o(st), .balance_mode_select_o(mode),
    .switch_enable_mask_o(mask), .first_expiry_limit_o(lim), .cell_settle_delay_o(cdl),
    .wire_settle_delay_o(wdl), .exit_level_from_lowest_o(low), .notify_wr_o(ntf), .switch_drive_o(drv),
    .settle_busy_o(sbusy), .settle_done_o(sdone));
  cbmc_meas_model u_meas (.ref_clk_i, .rst_n_i, .go_i(go), .start_o(mstart), .busy_o(mbusy));
  // Inputs move a fixed 2 ns after the edge so no race with sampling.
  task automatic tick(int k = 1);
    repeat (k) @(posedge ref_clk_i) #2;
  endtask
  // One write pulse, then the bundle returns to idle.
  task automatic put(cbmc_pkg::cbmc_wr_s x);
    w = x;
    tick();
    w = '0;
  endtask
  task automatic wmode(logic [2:0] m);
    put('{ctrl_we: 1'b1, mode: m, default: '0});
  endtask
  task automatic go_meas();
    go = 1'b1;
    tick();
    go = 1'b0;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic t_manual();
    put('{exp_we: 1'b1, exp_val: 10'h003, default: '0});
    wmode(3'h2);
    chk("state", 2'h1, st.state);
    chk("timer", 0, st.timer);
    put('{sw_we: 1'b1, sw_mask: 14'h0005, default: '0});
    tick();
    chk("drive", 14'h0005, drv);
    put('{exp_we: 1'b1, exp_val: 10'h3FF, default: '0});
    chk("limit", 10'h003, lim);
    chk("reject", 1, st.reject);
    pause = 1'b1;
    go_meas();
    tick(2);
    chk("paused", 0, drv);
    tick(8);
    chk("resumed", 14'h0005, drv);
    a = st.alive;
    tick(20);
    chk("alive", a + 2'h1, st.alive);
    put('{refresh: 1'b1, default: '0});
    tick();
    chk("refresh", 0, st.timer);
    tick(100);
    chk("exit", 2'h2, st.state);
    chk("stopped", 0, drv);
    chk("kept", 3'h2, mode);
    put('{refresh: 1'b1, default: '0});
    tick(2);
    chk("late", 0, drv);
    chk("late timer", 10'h004, st.timer);
    wmode(3'h2);
    chk("again", 2'h1, st.state);
    wmode(3'h0);
    chk("clear", 2'h0, st.state);
    pause = 1'b0;
    hok = 1'b0;
    wmode(3'h2);
    chk("health", 2'h3, st.state);
    chk("hflag", 1, st.health_fail);
    hok = 1'b1;
    wmode(3'h0);
    put('{exp_we: 1'b1, exp_val: 10'h3FF, default: '0});
    wmode(3'h2);
    tick(90);
    chk("nowatch", 14'h0005, drv);
    wmode(3'h0);
    $display("manual test done");
  endtask
  task automatic t_block();
    put('{notify_we: 1'b1, default: '0});
    chk("notify", 1, ntf);
    wmode(3'h1);
    put('{notify_we: 1'b1, default: '0});
    chk("notify", 0, ntf);
    chk("reject", 1, st.reject);
    put('{sw_we: 1'b1, sw_mask: 14'h0003, default: '0});
    chk("mask", 14'h0003, mask);
    put('{dly_we: 1'b1, wire_dly: 8'h07, default: '0});
    chk("wire", 8'h07, wdl);
    asw = 14'h2AAA;
    tick();
    chk("auto drive", 14'h2AAA, drv);
    therm = 1'b1;
    tick(2);
    chk("fault", 2'h3, st.state);
    chk("halted", 0, drv);
    therm = 1'b0;
    asw = 14'h0000;
    for (int m = 4; m < 8; m++) begin
      wmode(m[2:0]);
      put('{sw_we: 1'b1, sw_mask: 14'h3FFF, dly_we: 1'b1, cell_dly: 8'h11, default: '0});
      chk("mask", 14'h0003, mask);
      chk("delay", 0, cdl);
      chk("reject", 1, st.reject);
    end
    wmode(3'h3);
    go_meas();
    put('{uv_we: 1'b1, uv_lowest: 1'b1, dly_we: 1'b1, cell_dly: 8'h22, default: '0});
    chk("lowest", 0, low);
    chk("delay", 0, cdl);
    chk("reject", 1, st.reject);
    tick(8);
    put('{uv_we: 1'b1, uv_lowest: 1'b1, default: '0});
    chk("lowest", 1, low);
    wmode(3'h0);
    $display("blocking test done");
  endtask
  task automatic t_settle(logic s, int e);
    alt = s;
    go_meas();
    tick();
    n = 0;
    while (sdone !== 1'b1 && n < 99) begin
      tick();
      n++;
    end
    chk("settle", e, n);
    tick(8);
  endtask
  task automatic t_delay();
    put('{dly_we: 1'b1, cell_dly: 8'h02, wire_dly: 8'h01, default: '0});
    chk("cell", 8'h02, cdl);
    chk("wire", 8'h01, wdl);
    pause = 1'b1;
    t_settle(1'b0, 9);
    t_settle(1'b1, 5);
    $display("settle test done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    tick(10);
    rst_n_i = 1'b1;
    tick();
    chk("state", 0, st.state);
    chk("limit", 10'h3FF, lim);
    t_manual();
    t_block();
    t_delay();
    print_verdict();
  end
  initial begin
    #150000;
    fail_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
